/* File: design/mdsd_datapath.sv */
// Multiply, iterative divide and shift datapath of a 16-bit core.
// Assumes decode and pipeline control drive every input on ref_clk, and that
// the interrupt controller pulses irq_enter and irq_exit around each handler.
//
// Notes on behaviour
// - One 17x17 multiplier gives its product in one cycle and serves both the integer and the signal unit.
// - The multiplier treats operands as signed-signed, unsigned-unsigned or signed-unsigned per instruction.
// - Each 16-bit operand is extended to 17 bits first so that -1.0 times -1.0 is exact.
// - The divider does 16/16 and 32/16 divides, each in fractional or integer form.
// - A divide advances one step per instruction cycle and needs 19 cycles, issued by a repeat loop.
// - An interrupt may suspend a divide at any of its 19 cycles and it later resumes intact.
// - The 40-bit barrel shifter shifts left or right by up to 16 places in one cycle.
// - The shifter takes operands from, and serves, either execution unit.
`timescale 1ns/10ps
module mdsd_datapath (
  input  wire logic                                 ref_clk,
  input  wire logic                                 arst_n,
  // Multiplier
  input  wire logic                                 mul_valid,
  input  wire mdsd_pkg::mdsd_src_t                  mul_src,
  input  wire mdsd_pkg::mdsd_mul_mode_t             mul_mode,
  input  wire logic [mdsd_pkg::OP_W-1:0]            int_mul_a,
  input  wire logic [mdsd_pkg::OP_W-1:0]            int_mul_b,
  input  wire logic [mdsd_pkg::OP_W-1:0]            dsp_mul_a,
  input  wire logic [mdsd_pkg::OP_W-1:0]            dsp_mul_b,
  output logic [mdsd_pkg::PROD_W-1:0]               mul_product,
  output logic                                      mul_done,
  // Shifter
  input  wire logic                                 sh_valid,
  input  wire mdsd_pkg::mdsd_src_t                  sh_src,
  input  wire logic [mdsd_pkg::OP_W-1:0]            int_sh_operand,
  input  wire logic [mdsd_pkg::SH_W-1:0]            dsp_sh_operand,
  input  wire logic signed [mdsd_pkg::SH_AMT_W-1:0] sh_amt,
  input  wire logic                                 sh_arith,
  output logic [mdsd_pkg::SH_W-1:0]                 sh_result,
  output logic                                      sh_done,
  // Divider
  input  wire logic                                 div_valid,
  input  wire logic                                 div_first,
  input  wire logic                                 div_long,
  input  wire logic                                 div_signed,
  input  wire logic                                 div_frac,
  input  wire logic [mdsd_pkg::DIVD_W-1:0]          div_dividend,
  input  wire logic [mdsd_pkg::OP_W-1:0]            div_divisor,
  input  wire logic                                 irq_enter,
  input  wire logic                                 irq_exit,
  output logic [mdsd_pkg::OP_W-1:0]                 div_quotient,
  output logic [mdsd_pkg::OP_W-1:0]                 div_remainder,
  output logic                                      div_overflow,
  output logic                                      div_done,
  output logic                                      div_busy
);

  // Extend one 16-bit operand to 17 bits as signed or unsigned
  function automatic logic [mdsd_pkg::MUL_W-1:0] ext17(input logic [mdsd_pkg::OP_W-1:0] v, input logic sgn);
    ext17 = {sgn & v[mdsd_pkg::OP_W-1], v};
  endfunction

  // Two's complement negate when requested, 16 bits
  function automatic logic [mdsd_pkg::OP_W-1:0] neg16(input logic [mdsd_pkg::OP_W-1:0] v, input logic n);
    neg16 = n ? (~v + 16'h0001) : v;
  endfunction

  // Multiplier state
  logic [mdsd_pkg::PROD_W-1:0] prod_reg;
  logic [mdsd_pkg::PROD_W-1:0] prod_next;
  logic                        mul_done_reg;
  logic                        mul_done_next;
  logic [mdsd_pkg::OP_W-1:0]   ma;
  logic [mdsd_pkg::OP_W-1:0]   mb;
  logic                        a_sgn;
  logic                        b_sgn;
  logic signed [mdsd_pkg::MUL_W-1:0] ma17;
  logic signed [mdsd_pkg::MUL_W-1:0] mb17;

  // Operand routing, sign handling and the one-cycle product
  always_comb begin
    ma = (mul_src == mdsd_pkg::MDSD_SRC_INT) ? int_mul_a : dsp_mul_a;
    mb = (mul_src == mdsd_pkg::MDSD_SRC_INT) ? int_mul_b : dsp_mul_b;
    unique case (mul_mode)
      mdsd_pkg::MDSD_MUL_SS: begin
        a_sgn = 1'b1;
        b_sgn = 1'b1;
      end
      mdsd_pkg::MDSD_MUL_UU: begin
        a_sgn = 1'b0;
        b_sgn = 1'b0;
      end
      mdsd_pkg::MDSD_MUL_SU: begin
        a_sgn = 1'b1;
        b_sgn = 1'b0;
      end
      default: begin // Spare code behaves as unsigned
        a_sgn = 1'b0;
        b_sgn = 1'b0;
      end
    endcase
    // 17-bit extension keeps 0x8000 * 0x8000 from overflowing
    ma17 = $signed(ext17(ma, a_sgn));
    mb17 = $signed(ext17(mb, b_sgn));
    prod_next     = mul_valid ? PROD_CAST(ma17 * mb17) : prod_reg;
    mul_done_next = mul_valid;
  end

  // Product is 34 bits, exactly the signed 17x17 width
  function automatic logic [mdsd_pkg::PROD_W-1:0] PROD_CAST(input logic signed [mdsd_pkg::PROD_W-1:0] v);
    PROD_CAST = v;
  endfunction

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prod_reg     <= 34'h0_0000_0000;
      mul_done_reg <= 1'b0;
    end else begin
      prod_reg     <= prod_next;
      mul_done_reg <= mul_done_next;
    end
  end

  assign mul_product = prod_reg;
  assign mul_done    = mul_done_reg;

  // Shared barrel shifter
  mdsd_shifter u_shifter (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .sh_valid       (sh_valid),
    .sh_src         (sh_src),
    .int_sh_operand (int_sh_operand),
    .dsp_sh_operand (dsp_sh_operand),
    .sh_amt         (sh_amt),
    .sh_arith       (sh_arith),
    .sh_result      (sh_result),
    .sh_done        (sh_done)
  );

  // Divider state: live context, interrupt shadow and results
  mdsd_pkg::mdsd_div_ctx_t ctx_reg;
  mdsd_pkg::mdsd_div_ctx_t ctx_next;
  mdsd_pkg::mdsd_div_ctx_t shadow_reg;
  mdsd_pkg::mdsd_div_ctx_t shadow_next;
  logic [mdsd_pkg::OP_W-1:0] quo_out_reg;
  logic [mdsd_pkg::OP_W-1:0] quo_out_next;
  logic [mdsd_pkg::OP_W-1:0] rem_out_reg;
  logic [mdsd_pkg::OP_W-1:0] rem_out_next;
  logic                      ovf_out_reg;
  logic                      ovf_out_next;
  logic                      div_done_reg;
  logic                      div_done_next;
  logic [mdsd_pkg::DIVD_W-1:0] num;
  logic [mdsd_pkg::DIVD_W-1:0] nmag;
  logic [mdsd_pkg::OP_W-1:0]   dmag;
  logic                        nneg;
  logic                        dneg;
  logic [mdsd_pkg::OP_W:0]     trial;

  // One step per issued cycle; no step is taken while div_valid is low,
  // so an interrupt that stalls the repeat loop simply freezes the context
  always_comb begin
    ctx_next      = ctx_reg;
    shadow_next   = shadow_reg;
    quo_out_next  = quo_out_reg;
    rem_out_next  = rem_out_reg;
    ovf_out_next  = ovf_out_reg;
    div_done_next = 1'b0;
    // Dividend alignment for the four divide forms
    if (div_long) begin
      num = (div_frac && div_signed) ? {div_dividend[mdsd_pkg::DIVD_W-1], div_dividend[mdsd_pkg::DIVD_W-1:1]}
          : div_frac ? {1'b0, div_dividend[mdsd_pkg::DIVD_W-1:1]} : div_dividend;
    end else if (div_frac) begin
      num = {div_signed & div_dividend[mdsd_pkg::OP_W-1], div_dividend[mdsd_pkg::OP_W-1:0], 15'h0000};
    end else begin
      num = {{mdsd_pkg::OP_W{div_signed & div_dividend[mdsd_pkg::OP_W-1]}}, div_dividend[mdsd_pkg::OP_W-1:0]};
    end
    nneg  = div_signed & num[mdsd_pkg::DIVD_W-1];
    dneg  = div_signed & div_divisor[mdsd_pkg::OP_W-1];
    nmag  = nneg ? (~num + 32'h0000_0001) : num;
    dmag  = neg16(div_divisor, dneg);
    trial = {ctx_reg.rem[mdsd_pkg::OP_W-1:0], ctx_reg.quo[mdsd_pkg::OP_W-1]};
    if (div_valid && div_first) begin
      ctx_next.phase = mdsd_pkg::MDSD_DIV_ITER;
      ctx_next.cnt   = mdsd_pkg::DIV_CNT_LOAD + 5'h01;
      ctx_next.rem   = {1'b0, nmag[mdsd_pkg::DIVD_W-1:mdsd_pkg::OP_W]};
      ctx_next.quo   = nmag[mdsd_pkg::OP_W-1:0];
      ctx_next.den   = dmag;
      ctx_next.qneg  = nneg ^ dneg;
      ctx_next.rneg  = nneg;
      ctx_next.sgn   = div_signed;
      ctx_next.ovf   = (dmag == 16'h0000) || (nmag[mdsd_pkg::DIVD_W-1:mdsd_pkg::OP_W] >= dmag);
    end else if (div_valid) begin
      unique case (ctx_reg.phase)
        mdsd_pkg::MDSD_DIV_IDLE: begin
          ctx_next = ctx_reg;
        end
        mdsd_pkg::MDSD_DIV_ITER: begin
          // Restoring step: remainder stays below the divisor
          if (trial >= {1'b0, ctx_reg.den}) begin
            ctx_next.rem = trial - {1'b0, ctx_reg.den};
            ctx_next.quo = {ctx_reg.quo[mdsd_pkg::OP_W-2:0], 1'b1};
          end else begin
            ctx_next.rem = trial;
            ctx_next.quo = {ctx_reg.quo[mdsd_pkg::OP_W-2:0], 1'b0};
          end
          ctx_next.cnt = ctx_reg.cnt + 5'h01;
          if (ctx_reg.cnt == mdsd_pkg::DIV_CNT_ITER) begin
            ctx_next.phase = mdsd_pkg::MDSD_DIV_FIX;
          end
        end
        mdsd_pkg::MDSD_DIV_FIX: begin
          // Apply signs and catch a quotient too large for 16 signed bits
          ctx_next.quo = neg16(ctx_reg.quo, ctx_reg.qneg);
          ctx_next.rem = {1'b0, neg16(ctx_reg.rem[mdsd_pkg::OP_W-1:0], ctx_reg.rneg)};
          ctx_next.ovf = ctx_reg.ovf | (ctx_reg.sgn && (ctx_reg.quo > mdsd_pkg::QUO_MAX_POS)
                         && !(ctx_reg.qneg && ctx_reg.quo == mdsd_pkg::QUO_MIN_NEG));
          ctx_next.cnt   = mdsd_pkg::DIV_CNT_LAST;
          ctx_next.phase = mdsd_pkg::MDSD_DIV_LAST;
        end
        mdsd_pkg::MDSD_DIV_LAST: begin
          quo_out_next   = ctx_reg.quo;
          rem_out_next   = ctx_reg.rem[mdsd_pkg::OP_W-1:0];
          ovf_out_next   = ctx_reg.ovf;
          div_done_next  = 1'b1;
          ctx_next.cnt   = mdsd_pkg::DIV_CNT_LOAD;
          ctx_next.phase = mdsd_pkg::MDSD_DIV_IDLE;
        end
      endcase
    end
    // Interrupt entry snapshots the frozen context; exit puts it back,
    // so a divide issued inside the handler cannot corrupt the outer one
    if (irq_enter) begin
      shadow_next = ctx_reg;
    end
    if (irq_exit) begin
      ctx_next = shadow_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctx_reg      <= mdsd_pkg::DIV_CTX_RESET;
      shadow_reg   <= mdsd_pkg::DIV_CTX_RESET;
      quo_out_reg  <= 16'h0000;
      rem_out_reg  <= 16'h0000;
      ovf_out_reg  <= 1'b0;
      div_done_reg <= 1'b0;
    end else begin
      ctx_reg      <= ctx_next;
      shadow_reg   <= shadow_next;
      quo_out_reg  <= quo_out_next;
      rem_out_reg  <= rem_out_next;
      ovf_out_reg  <= ovf_out_next;
      div_done_reg <= div_done_next;
    end
  end

  assign div_quotient  = quo_out_reg;
  assign div_remainder = rem_out_reg;
  assign div_overflow  = ovf_out_reg;
  assign div_done      = div_done_reg;
  assign div_busy      = (ctx_reg.phase != mdsd_pkg::MDSD_DIV_IDLE);

endmodule

/* File: design/mdsd_pkg.sv */
// Shared constants and types for the multiply, divide and shift datapath.
// Assumes all users reference names as mdsd_pkg::name without importing.
package mdsd_pkg;

  // Operand and result widths
  localparam int unsigned OP_W       = 16;
  localparam int unsigned MUL_W      = 17;
  localparam int unsigned PROD_W     = 34;
  localparam int unsigned SH_W       = 40;
  localparam int unsigned SH_AMT_W   = 6;
  localparam int unsigned DIVD_W     = 32;

  // Largest shift distance in either direction
  localparam logic [SH_AMT_W-1:0] SH_MAX = 6'h10;

  // Divide timing in instruction cycles
  localparam int unsigned DIV_CYCLES = 19;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] DIV_CNT_LOAD = 5'h00;
  localparam logic [CNT_W-1:0] DIV_CNT_ITER = 5'h10;
  localparam logic [CNT_W-1:0] DIV_CNT_FIX  = 5'h11;
  localparam logic [CNT_W-1:0] DIV_CNT_LAST = 5'h12;

  // Largest positive and most negative signed quotients
  localparam logic [OP_W-1:0] QUO_MAX_POS = 16'h7fff;
  localparam logic [OP_W-1:0] QUO_MIN_NEG = 16'h8000;

  // Operand interpretation for the multiplier
  typedef enum logic [1:0] {
    MDSD_MUL_SS,
    MDSD_MUL_UU,
    MDSD_MUL_SU
  } mdsd_mul_mode_t;

  // Which execution unit owns the operands
  typedef enum logic {
    MDSD_SRC_INT,
    MDSD_SRC_DSP
  } mdsd_src_t;

  // Divider progress
  typedef enum logic [1:0] {
    MDSD_DIV_IDLE,
    MDSD_DIV_ITER,
    MDSD_DIV_FIX,
    MDSD_DIV_LAST
  } mdsd_div_phase_t;

  // Complete divider context; saved and restored as one unit
  typedef struct packed {
    mdsd_div_phase_t  phase;
    logic [CNT_W-1:0] cnt;
    logic [OP_W:0]    rem;
    logic [OP_W-1:0]  quo;
    logic [OP_W-1:0]  den;
    logic             qneg;
    logic             rneg;
    logic             sgn;
    logic             ovf;
  } mdsd_div_ctx_t;

  localparam mdsd_div_ctx_t DIV_CTX_RESET = '{
    phase: MDSD_DIV_IDLE, cnt: 5'h00, rem: 17'h0_0000, quo: 16'h0000,
    den: 16'h0000, qneg: 1'b0, rneg: 1'b0, sgn: 1'b0, ovf: 1'b0};

endpackage

/* File: design/mdsd_shifter.sv */
// Single-cycle 40-bit barrel shifter with operand routing from either unit.
// Assumes control inputs come from decode logic on ref_clk.
`timescale 1ns/10ps
module mdsd_shifter (
  input  wire logic                              ref_clk,
  input  wire logic                              arst_n,
  input  wire logic                              sh_valid,
  input  wire mdsd_pkg::mdsd_src_t               sh_src,
  input  wire logic [mdsd_pkg::OP_W-1:0]         int_sh_operand,
  input  wire logic [mdsd_pkg::SH_W-1:0]         dsp_sh_operand,
  input  wire logic signed [mdsd_pkg::SH_AMT_W-1:0] sh_amt,
  input  wire logic                              sh_arith,
  output logic [mdsd_pkg::SH_W-1:0]              sh_result,
  output logic                                   sh_done
);

  logic [mdsd_pkg::SH_W-1:0] result_reg;
  logic [mdsd_pkg::SH_W-1:0] result_next;
  logic                      done_reg;
  logic                      done_next;
  logic [mdsd_pkg::SH_W-1:0] operand;
  logic [mdsd_pkg::SH_AMT_W-1:0] mag;

  // Route operand and compute the shift; amounts beyond 16 saturate
  always_comb begin
    if (sh_src == mdsd_pkg::MDSD_SRC_INT) begin
      operand = sh_arith ? {{(mdsd_pkg::SH_W-mdsd_pkg::OP_W){int_sh_operand[mdsd_pkg::OP_W-1]}}, int_sh_operand}
                         : {{(mdsd_pkg::SH_W-mdsd_pkg::OP_W){1'b0}}, int_sh_operand};
    end else begin
      operand = dsp_sh_operand;
    end
    mag = sh_amt[mdsd_pkg::SH_AMT_W-1] ? (~sh_amt + 6'h01) : sh_amt;
    if (mag > mdsd_pkg::SH_MAX) begin
      mag = mdsd_pkg::SH_MAX;
    end
    result_next = result_reg;
    done_next   = sh_valid;
    if (sh_valid) begin
      // Separate branches keep the arithmetic shift signed; a ternary would make it logical
      if (sh_amt[mdsd_pkg::SH_AMT_W-1]) begin
        if (sh_arith) begin
          result_next = $signed(operand) >>> mag;
        end else begin
          result_next = operand >> mag;
        end
      end else begin
        result_next = operand << mag;
      end
    end
  end

  // Result registered on the same edge that takes the request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 40'h00_0000_0000;
      done_reg   <= 1'b0;
    end else begin
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  assign sh_result = result_reg;
  assign sh_done   = done_reg;

endmodule

/* File: dv/mdsd_datapath_sva.sv */
// Port-level checks for the multiply, divide and shift datapath.
// Assumes it is bound to mdsd_datapath; one clock, async active-low reset.
`timescale 1ns/10ps
module mdsd_datapath_sva (
  input wire logic                     ref_clk,
  input wire logic                     arst_n,
  input wire logic                     mul_valid,
  input wire mdsd_pkg::mdsd_src_t      mul_src,
  input wire mdsd_pkg::mdsd_mul_mode_t mul_mode,
  input wire logic [15:0]              int_mul_a,
  input wire logic [15:0]              int_mul_b,
  input wire logic [33:0]              mul_product,
  input wire logic                     mul_done,
  input wire logic                     sh_valid,
  input wire logic [39:0]              sh_result,
  input wire logic                     sh_done,
  input wire logic                     div_valid,
  input wire logic                     div_first,
  input wire logic                     irq_enter,
  input wire logic                     irq_exit,
  input wire logic [15:0]              div_quotient,
  input wire logic [15:0]              div_remainder,
  input wire logic                     div_done,
  input wire logic                     div_busy
);
  logic [4:0] nstep_reg;
  logic       clean_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Steps since the last load; a context swap spoils the count, so skip those
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nstep_reg <= 5'h00;
      clean_reg <= 1'b0;
    end else if (div_valid && div_first) begin
      nstep_reg <= 5'h01;
      clean_reg <= 1'b1;
    end else begin
      nstep_reg <= nstep_reg + {4'h0, div_valid};
      clean_reg <= clean_reg && !irq_enter && !irq_exit;
    end
  end

  chk_mul_lat: assert property (mul_valid |=> mul_done) else $error("no mul done");
  chk_mul_cause: assert property (mul_done |-> $past(mul_valid)) else $error("stray mul done");
  chk_mul_hold: assert property (!mul_valid |=> $stable(mul_product)) else $error("product moved");
  chk_mul_exact: assert property (mul_valid && mul_src == mdsd_pkg::MDSD_SRC_INT &&
    mul_mode == mdsd_pkg::MDSD_MUL_SS && int_mul_a == 16'h8000 && int_mul_b == 16'h8000
    |=> mul_product == 34'h0_4000_0000) else $error("corner product wrong");
  chk_sh_lat: assert property (sh_valid |=> sh_done) else $error("no shift done");
  chk_sh_hold: assert property (!sh_valid |=> $stable(sh_result)) else $error("shift moved");
  chk_div_busy: assert property (div_valid && div_first |=> div_busy) else $error("not busy");
  chk_div_count: assert property (div_done && clean_reg |-> nstep_reg == 5'h13) else $error("step count");
  chk_div_cause: assert property (div_done |-> $past(div_valid) && !div_busy) else $error("bad done");
  chk_div_hold: assert property (!div_done |-> $stable(div_quotient) && $stable(div_remainder))
    else $error("result moved");
endmodule

bind mdsd_datapath mdsd_datapath_sva u_sva (.ref_clk, .arst_n, .mul_valid, .mul_src, .mul_mode,
  .int_mul_a, .int_mul_b, .mul_product, .mul_done, .sh_valid, .sh_result, .sh_done, .div_valid,
  .div_first, .irq_enter, .irq_exit, .div_quotient, .div_remainder, .div_done, .div_busy);

/* File: dv/mdsd_issue_model.sv */
// Issue side of the core: repeats a divide step, with stalls and a saved count.
// Assumes go, slow, hold and the irq pulses come from the bench on ref_clk.
`timescale 1ns/10ps
module mdsd_issue_model (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic hold,
  input  wire logic irq_enter,
  input  wire logic irq_exit,
  output logic      div_valid,
  output logic      div_first
);
  logic [4:0] left_reg;
  logic [4:0] left_next;
  logic [4:0] shd_reg;
  logic       tog_reg;

  // Steps still owed; a step counts once the datapath has seen it valid
  always_comb begin
    if (go) left_next = 5'h13;
    else if (irq_exit) left_next = shd_reg;
    else left_next = left_reg - {4'h0, div_valid};
  end

  // Slow mode leaves gaps, which the divider must tolerate
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {left_reg, shd_reg, tog_reg, div_valid, div_first} <= '0;
    end else begin
      left_reg <= left_next;
      tog_reg <= ~tog_reg;
      if (irq_enter) shd_reg <= left_reg;
      div_first <= go;
      div_valid <= go || (left_next != 5'h00 && !hold && !(slow && tog_reg));
    end
  end
endmodule

/* File: dv/mdsd_testbench.sv */
// Self-checking bench for the datapath: multiply, shift, divide, interrupt.
// Assumes the issue model drives the divide steps; all else from the bench.
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 0, arst_n = 0, mul_valid = 0, sh_valid = 0, sh_arith = 0;
  logic div_long = 0, div_signed = 0, div_frac = 0, irq_enter = 0, irq_exit = 0;
  logic go = 0, slow = 0, hold = 0, div_valid, div_first, mul_done, sh_done;
  logic div_overflow, div_done, div_busy;
  mdsd_pkg::mdsd_src_t mul_src = mdsd_pkg::MDSD_SRC_INT, sh_src = mdsd_pkg::MDSD_SRC_INT;
  mdsd_pkg::mdsd_mul_mode_t mul_mode = mdsd_pkg::MDSD_MUL_SS;
  logic [15:0] int_mul_a = 0, int_mul_b = 0, dsp_mul_a = 0, dsp_mul_b = 0, int_sh_operand = 0;
  logic [15:0] div_divisor = 0, div_quotient, div_remainder;
  logic [31:0] div_dividend = 0;
  logic [39:0] dsp_sh_operand = 0, sh_result;
  logic [33:0] mul_product;
  logic signed [5:0] sh_amt = 0;
  int n_mismatch = 0, checks = 0;

  mdsd_datapath DUT (.ref_clk, .arst_n, .mul_valid, .mul_src, .mul_mode, .int_mul_a, .int_mul_b,
    .dsp_mul_a, .dsp_mul_b, .mul_product, .mul_done, .sh_valid, .sh_src, .int_sh_operand,
    .dsp_sh_operand, .sh_amt, .sh_arith, .sh_result, .sh_done, .div_valid, .div_first, .div_long,
    .div_signed, .div_frac, .div_dividend, .div_divisor, .irq_enter, .irq_exit, .div_quotient,
    .div_remainder, .div_overflow, .div_done, .div_busy);
  mdsd_issue_model u_issue (.ref_clk, .arst_n, .go, .slow, .hold, .irq_enter, .irq_exit,
    .div_valid, .div_first);

  initial forever #2 ref_clk = ~ref_clk;

  task automatic conclude;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Operands widened to 17 bits so the most negative fraction squares exactly
  function automatic logic [33:0] mulx(input logic [15:0] a, b, input int md);
    logic signed [16:0] ea, eb;
    ea = (md == 1 || md == 3) ? {1'b0, a} : {a[15], a};
    eb = (md == 0) ? {b[15], b} : {1'b0, b};
    return 34'(34'(ea) * 34'(eb));
  endfunction

  function automatic logic [39:0] shx(input logic [39:0] v, input int n, input logic ar);
    int m;
    m = (n > 16) ? 16 : (n < -16) ? -16 : n;
    if (m >= 0) return v << m;
    if (ar) return $signed(v) >>> (-m);
    return v >> (-m);
  endfunction

  // Back-to-back multiplies; the idle unit's operands are inverted to catch misrouting
  // The spare mode code is included and must behave as unsigned
  task automatic t_mul;
    logic [15:0] a, b;
    for (int i = 0; i < 24; i++) begin
      a = (i % 3 == 0) ? 16'h8000 : (i % 3 == 1) ? 16'hffff : 16'h1234;
      b = (i % 3 == 0) ? 16'h8000 : (i % 3 == 1) ? 16'h7fff : 16'hfedc;
      mul_mode = mdsd_pkg::mdsd_mul_mode_t'(i / 6);
      mul_src = mdsd_pkg::mdsd_src_t'(i[0]);
      {int_mul_a, int_mul_b} = i[0] ? ~{a, b} : {a, b};
      {dsp_mul_a, dsp_mul_b} = i[0] ? {a, b} : ~{a, b};
      mul_valid = 1;
      @(posedge ref_clk);
      #1;
      chk(40'(mul_product), 40'(mulx(a, b, i / 6)));
      chk(40'(mul_done), 40'h1);
    end
    mul_valid = 0;
  endtask

  // Amounts from -20 to 20 so both saturation edges are crossed
  task automatic t_sh;
    logic [39:0] v;
    for (int i = 0; i < 11; i++) begin
      sh_src = mdsd_pkg::mdsd_src_t'(i[0]);
      sh_arith = i[1];
      sh_amt = 6'(i * 4 - 20);
      int_sh_operand = 16'h8c31;
      dsp_sh_operand = 40'h9a_5c3e_71b4;
      v = i[0] ? dsp_sh_operand : {{24{i[1]}}, 16'h8c31};
      sh_valid = 1;
      @(posedge ref_clk);
      #1;
      chk(sh_result, shx(v, i * 4 - 20, i[1]));
      chk(40'(sh_done), 40'h1);
    end
    sh_valid = 0;
  endtask

  task automatic run_div(input logic l, s, f, input logic [31:0] d, input logic [15:0] v,
                         input logic sl);
    {div_long, div_signed, div_frac, slow} = {l, s, f, sl};
    div_dividend = d;
    div_divisor = v;
    go = 1;
    @(posedge ref_clk);
    #1;
    go = 0;
  endtask

  task automatic wait_div(input logic [15:0] q, r, input logic o);
    for (int i = 0; i < 90 && div_done !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(40'(div_done), 40'h1);
    chk(40'(div_busy), 40'h0);
    chk(40'(div_overflow), 40'(o));
    if (!o) chk(40'({div_quotient, div_remainder}), 40'({q, r}));
  endtask

  // Every width and form, with gaps between steps on some
  task automatic t_div;
    run_div(0, 0, 0, 32'h0000_03e8, 16'h0007, 0);
    wait_div(16'h008e, 16'h0006, 0);
    run_div(0, 1, 0, 32'h0000_fc18, 16'h0007, 1);
    wait_div(16'hff72, 16'hfffa, 0);
    run_div(0, 1, 1, 32'h0000_2000, 16'h4000, 0);
    wait_div(16'h4000, 16'h0000, 0);
    run_div(1, 0, 0, 32'h0001_86a7, 16'h03e8, 1);
    wait_div(16'h0064, 16'h0007, 0);
    run_div(1, 1, 1, 32'h2000_0000, 16'h4000, 0);
    wait_div(16'h4000, 16'h0000, 0);
    run_div(1, 0, 0, 32'h0000_1234, 16'h0000, 0);
    wait_div(16'h0000, 16'h0000, 1);
  endtask

  // Suspend after k+1 steps, run a whole divide in the handler, then resume
  task automatic t_irq(input int k);
    run_div(0, 1, 0, 32'h0000_fc18, 16'h0007, 0);
    repeat (k) begin
      @(posedge ref_clk);
      #1;
    end
    hold = 1;
    repeat (2) @(posedge ref_clk);
    #1 irq_enter = 1;
    @(posedge ref_clk);
    #1 {irq_enter, hold} = 2'b00;
    run_div(1, 0, 0, 32'h0001_86a7, 16'h03e8, 0);
    wait_div(16'h0064, 16'h0007, 0);
    {hold, irq_exit} = 2'b11;
    @(posedge ref_clk);
    #1 {irq_exit, hold} = 2'b00;
    wait_div(16'hff72, 16'hfffa, 0);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 arst_n = 1;
    chk(40'({mul_done, sh_done, div_done, div_busy}), 40'h0);
    t_mul;
    t_sh;
    t_div;
    t_irq(0);
    t_irq(9);
    t_irq(17);
    conclude;
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #20000;
    n_mismatch++;
    conclude;
  end
endmodule
